//--- verilog/dpl_device.sv
// Converter front end: latches sample words and forms current codes
// Summary of operation
// - Ten-bit unsigned binary word, MSB first
// - Edge-triggered capture ignores mid-cycle input changes
// - Output updates only on sample edge, except that sleep entry clears it on the next clock
// - Code 1023: true full, complement zero
// - True is code, complement is 1023 minus code
// - Source keeps both clock phases wide enough
// - Source changes data on falling phase
// - Strap selects single, differential or PECL mode
// - Single-ended mode drives positive input only
// - Floating strap enables PECL termination
// - Sleep high powers down outputs
// - Down within 50 ns, wake 5 us
`timescale 1ns/1ps
module dpl_device
	import dpl_pkg::*;
#(
	parameter int WAKE_CYCLES = SLEEP_EXIT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link
	dpl_link_if.device link,
	// Converter outputs
	output logic [DATA_W-1:0] true_current_output,
	output logic [DATA_W-1:0] complement_current_output,
	output logic output_valid,
	output logic powered_down,
	// Clock receiver controls
	output logic [1:0] clock_mode,
	output logic pecl_term_en
);
	typedef enum logic [1:0] {DPL_RUN, DPL_SLEEP, DPL_WAKE} dpl_pwr_type;
	dpl_pwr_type pwr_reg, pwr_next;
	logic [12:0] wake_cnt_reg, wake_cnt_next;
	logic [DATA_W-1:0] code_reg;
	logic [DATA_W-1:0] true_reg;
	logic [DATA_W-1:0] comp_reg;
	logic valid_reg;
	logic down_reg;
	logic [1:0] mode_reg;
	logic pecl_reg;
	logic [1:0] strap_ff1_reg;
	logic [1:0] strap_ff2_reg;
	dpl_clk_mode_type mode_next;
	// Complement is full code minus the code, never negative
	function automatic logic [DATA_W-1:0] comp_code(input logic [DATA_W-1:0] c);
		comp_code = CODE_FULL - c;
	endfunction
	// Strap decode; unknown codes fall back to PECL as a float would
	assign mode_next = (strap_ff2_reg == STRAP_GND) ? DPL_CLK_SINGLE :
		(strap_ff2_reg == STRAP_SUPPLY) ? DPL_CLK_DIFF : DPL_CLK_PECL;
	wire running = (pwr_reg == DPL_RUN);
	// Capture only on the sample edge
	wire capture = link.sample_en;
	// Power state: sleep takes one cycle, well inside the entry limit
	always_comb
	begin
		pwr_next = pwr_reg;
		wake_cnt_next = wake_cnt_reg;
		unique case (pwr_reg)
			DPL_RUN:
				if (link.sleep)
					pwr_next = DPL_SLEEP;
			DPL_SLEEP:
				if (!link.sleep)
				begin
					pwr_next = DPL_WAKE;
					wake_cnt_next = '0;
				end
			DPL_WAKE:
				if (link.sleep)
					pwr_next = DPL_SLEEP;
				else if (wake_cnt_reg == 13'(WAKE_CYCLES - 1))
					pwr_next = DPL_RUN;
				else
					wake_cnt_next = wake_cnt_reg + 13'h0001;
		endcase
	end
	// Strap synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_ff1_reg <= STRAP_GND;
			strap_ff2_reg <= STRAP_GND;
			mode_reg <= 2'h0;
			pecl_reg <= 1'b0;
		end
		else
		begin
			strap_ff1_reg <= link.clock_mode_strap;
			strap_ff2_reg <= strap_ff1_reg;
			mode_reg <= mode_next;
			pecl_reg <= (mode_next == DPL_CLK_PECL);
		end
	end
	// Power state register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwr_reg <= DPL_RUN;
			wake_cnt_reg <= '0;
		end
		else
		begin
			pwr_reg <= pwr_next;
			wake_cnt_reg <= wake_cnt_next;
		end
	end
	// Code latch loads the link word on every capture, outputs only when the next power state is run; held between edges
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_reg <= '0;
			true_reg <= '0;
			comp_reg <= CODE_FULL;
			valid_reg <= 1'b0;
			down_reg <= 1'b0;
		end
		else
		begin
			down_reg <= (pwr_next != DPL_RUN);
			if (capture)
				code_reg <= link.sample_word;
			if (pwr_next != DPL_RUN)
			begin
				// Currents off in sleep and while waking
				true_reg <= '0;
				comp_reg <= '0;
				valid_reg <= 1'b0;
			end
			else if (capture)
			begin
				true_reg <= link.sample_word;
				comp_reg <= comp_code(link.sample_word);
				valid_reg <= running;
			end
		end
	end
	assign true_current_output = true_reg;
	assign complement_current_output = comp_reg;
	assign output_valid = valid_reg;
	assign powered_down = down_reg;
	assign clock_mode = mode_reg;
	assign pecl_term_en = pecl_reg;
endmodule // dpl_device

//--- include/dpl_pkg.sv
// Shared constants and types for the parallel input latch link
package dpl_pkg;
	localparam int DATA_W = 10;
	localparam logic [9:0] CODE_FULL = 10'h3FF;
	localparam logic [10:0] CODE_SPAN = 11'h400;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SLEEP_ENTER_NS = 50;
	localparam int SLEEP_EXIT_NS = 5000;
	// Entry is a longest time: round down, at least one cycle
	localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(SLEEP_ENTER_NS / CLK_PERIOD_NS);
	// Wake is a least time: round up
	localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_DIV = 2;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_SUPPLY = 2'h1;
	localparam logic [1:0] STRAP_FLOAT = 2'h2;
	typedef enum logic [1:0] {DPL_CLK_SINGLE, DPL_CLK_DIFF, DPL_CLK_PECL} dpl_clk_mode_type;
endpackage

//--- include/dpl_link_if.sv
// Interface joining the data source and the converter front end
`timescale 1ns/1ps
interface dpl_link_if;
	import dpl_pkg::*;
	logic sample_en;
	logic [DATA_W-1:0] sample_word;
	logic sleep;
	logic [1:0] clock_mode_strap;
	modport source (output sample_en, output sample_word, output sleep,
		output clock_mode_strap);
	modport device (input sample_en, input sample_word, input sleep,
		input clock_mode_strap);
endinterface

//--- verilog/dpl_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dpl_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic ready_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	// Ready comes from a flop so the upstream port is registered
	assign in_ready = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	// Storage writes need no reset
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end
	// Pointers wrap because depth is a power of two
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
		end
	end
endmodule // dpl_fifo

//--- verilog/dpl_source.sv
// Upstream data source: buffers words and presents them mid-sample
`timescale 1ns/1ps
module dpl_source
	import dpl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// User side
	input wire logic user_valid,
	output logic user_ready,
	input wire logic [DATA_W-1:0] user_word,
	input wire logic user_sleep,
	input wire logic [1:0] user_strap,
	// Link
	dpl_link_if.source link
);
	logic div_reg;
	logic en_reg;
	logic [DATA_W-1:0] word_reg;
	logic sleep_reg;
	logic [1:0] strap_reg;
	logic fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	// Word changes half a sample before capture, mimicking the falling edge
	wire change_phase = (div_reg == 1'b0);
	wire take = change_phase && fifo_valid;
	dpl_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(user_valid),
		.in_ready(user_ready),
		.in_data(user_word),
		.out_valid(fifo_valid),
		.out_ready(take),
		.out_data(fifo_data)
	);
	// Sample rate divider; high and low phases equal
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg <= 1'b0;
			en_reg <= 1'b0;
			word_reg <= '0;
			sleep_reg <= 1'b0;
			strap_reg <= STRAP_GND;
		end
		else
		begin
			div_reg <= ~div_reg;
			en_reg <= change_phase;
			sleep_reg <= user_sleep;
			strap_reg <= user_strap;
			if (take)
				word_reg <= fifo_data;
		end
	end
	assign link.sample_en = en_reg;
	assign link.sample_word = word_reg;
	assign link.sleep = sleep_reg;
	assign link.clock_mode_strap = strap_reg;
endmodule // dpl_source

//--- tb/dpl_link_checker.sv
// Assertions on the link and converter outputs
`timescale 1ns/1ps
module dpl_link_checker
	import dpl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link
	input wire logic sample_en,
	input wire logic [DATA_W-1:0] sample_word,
	input wire logic sleep,
	input wire logic [1:0] clock_mode_strap,
	// Converter
	input wire logic [DATA_W-1:0] true_current_output,
	input wire logic [DATA_W-1:0] complement_current_output,
	input wire logic output_valid,
	input wire logic powered_down,
	input wire logic [1:0] clock_mode,
	input wire logic pecl_term_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Code 3 falls to the terminated mode
	wire [1:0] exp_mode = (clock_mode_strap == STRAP_GND) ? 2'h0 :
		(clock_mode_strap == STRAP_SUPPLY) ? 2'h1 : 2'h2;
	capture_word_a: assert property (sample_en && !sleep && output_valid |=>
		true_current_output == $past(sample_word)) else $error("capture wrong");
	hold_word_a: assert property (!sample_en && !sleep && output_valid |=>
		$stable(true_current_output)) else $error("output moved");
	comp_code_a: assert property (output_valid |->
		complement_current_output == CODE_FULL - true_current_output) else $error("comp");
	sleep_entry_a: assert property (sleep |=> powered_down && true_current_output == 0 &&
		complement_current_output == 0) else $error("sleep entry");
	down_invalid_a: assert property (powered_down |-> !output_valid) else $error("valid");
	wake_wait_a: assert property ($fell(sleep) |-> !output_valid [*4]) else $error("wake");
	pace_a: assert property (sample_en |=> !sample_en) else $error("pace");
	// Strap crosses two synchroniser stages and the mode flop, so it must settle first
	strap_mode_a: assert property ($stable(clock_mode_strap) [*3] |-> clock_mode == exp_mode &&
		pecl_term_en == (exp_mode == 2'h2)) else $error("mode");
endmodule // dpl_link_checker

//--- tb/tb_top.sv
// Bench joining source and converter front end
`timescale 1ns/1ps
module tb_top;
	import dpl_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic user_valid = 1'b0;
	logic user_ready;
	logic [DATA_W-1:0] user_word = 10'h000;
	logic user_sleep = 1'b0;
	logic [1:0] user_strap = 2'h0;
	logic [DATA_W-1:0] tco;
	logic [DATA_W-1:0] cco;
	logic ov;
	logic pd;
	logic [1:0] cm;
	logic pt;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	int i;
	logic full_seen = 1'b0;
	logic mon_on = 1'b0;
	logic [DATA_W-1:0] last_seen = 10'h000;
	logic [DATA_W-1:0] e;
	logic [DATA_W-1:0] exp_q[$];
	dpl_link_if u_dpl_link_if ();
	dpl_source u_dpl_source (.ref_clk(ref_clk), .rst_n(rst_n), .user_valid(user_valid),
		.user_ready(user_ready), .user_word(user_word), .user_sleep(user_sleep),
		.user_strap(user_strap), .link(u_dpl_link_if));
	// Short wake keeps the run brief
	dpl_device #(.WAKE_CYCLES(4)) u_dpl_device (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(u_dpl_link_if), .true_current_output(tco), .complement_current_output(cco),
		.output_valid(ov), .powered_down(pd), .clock_mode(cm), .pecl_term_en(pt));
	dpl_link_checker u_dpl_link_checker (.ref_clk(ref_clk), .rst_n(rst_n),
		.sample_en(u_dpl_link_if.sample_en), .sample_word(u_dpl_link_if.sample_word),
		.sleep(u_dpl_link_if.sleep), .clock_mode_strap(u_dpl_link_if.clock_mode_strap),
		.true_current_output(tco), .complement_current_output(cco), .output_valid(ov),
		.powered_down(pd), .clock_mode(cm), .pecl_term_en(pt));
	always #12.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready is read mid-cycle, where it has settled
	task automatic push(input logic [DATA_W-1:0] w);
		user_valid <= 1'b1;
		user_word <= w;
		@(negedge ref_clk);
		while (user_ready !== 1'b1)
		begin
			full_seen = 1'b1;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
		exp_q.push_back(w);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Each new valid word must be the next one sent
	always @(negedge ref_clk)
		if (mon_on && ov === 1'b1 && tco !== last_seen)
		begin
			last_seen = tco;
			e = exp_q.pop_front();
			chk(tco, e);
			chk(cco, CODE_FULL - e);
		end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Strap needs the link flop, two sync stages and the mode flop: look mid-cycle later
		for (i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			user_strap <= i[1:0];
			repeat (6) @(negedge ref_clk);
			chk({8'h00, cm}, (i > 1) ? 10'h002 : i[9:0]);
			chk({9'h000, pt}, {9'h000, i > 1});
		end
		@(posedge ref_clk);
		// Back to back words overrun the drain rate and fill the buffer
		mon_on = 1'b1;
		for (i = 0; i < 20; i++)
			push(10'((i * 53 + 1) % 1024));
		user_valid <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chk(10'(exp_q.size()), 10'h000);
		chk({9'h000, full_seen}, 10'h001);
		mon_on = 1'b0;
		user_sleep <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk({9'h000, pd}, 10'h001);
		chk(tco | cco, 10'h000);
		@(posedge ref_clk);
		user_sleep <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({9'h000, ov}, 10'h000);
		repeat (20) @(posedge ref_clk);
		// All ones drives the true side to full scale and the complement to nothing
		push(10'h3FF);
		user_valid <= 1'b0;
		repeat (8) @(negedge ref_clk);
		chk(tco, 10'h3FF);
		chk(cco, 10'h000);
		chk({9'h000, ov}, 10'h001);
		chk({9'h000, pd}, 10'h000);
		@(posedge ref_clk);
		push(10'h2C7);
		user_valid <= 1'b0;
		repeat (8) @(negedge ref_clk);
		chk(tco, 10'h2C7);
		chk(cco, 10'h138);
		end_sim();
	end
endmodule // tb_top
